// [src/fsi_core.sv]
// Design decisions made here: the frame checks on the sink side and the store that holds one frame for the output side.
`default_nettype none
module fsi_core
   import fsi_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   fsi_stream_if.core st
);

   // ------------------------------------------------------------------
   // types and helpers
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_FILL  = 2'b01,
      ST_DRAIN = 2'b10
   } fsi_state_type;

   // a count of zero stands for the largest frame
   function automatic logic [LEN_W-1:0] frame_len(input logic [PTS_W-1:0] pts);
      if (pts == '0)
      begin
         frame_len = LEN_W'(MAX_PTS);
      end
      else
      begin
         frame_len = {1'b0, pts};
      end
   endfunction : frame_len

   fsi_state_type              state_q;
   fsi_state_type              state_d;
   logic [PTS_W-1:0]           wr_idx_q;
   logic [PTS_W-1:0]           rd_idx_q;
   logic                       in_frame_q;
   logic [PTS_W-1:0]           pts_q;
   logic                       inv_q;
   logic [PTS_W-1:0]           out_pts_q;
   logic                       out_inv_q;
   logic [ERR_W-1:0]           up_err_q;
   logic [ERR_W-1:0]           own_err_q;
   logic [ERR_W-1:0]           own_err_d;
   logic                       sink_ready_q;
   logic                       src_valid_q;
   logic                       src_sop_q;
   logic                       src_eop_q;
   logic [ERR_W-1:0]           src_err_q;
   logic [EXP_W-1:0]           src_exp_q;
   logic [PTS_W-1:0]           src_pts_q;
   logic signed [OUT_W-1:0]    src_real_q;
   logic signed [OUT_W-1:0]    src_imag_q;
   logic signed [DATA_W-1:0]   mem_re [MAX_PTS];
   logic signed [DATA_W-1:0]   mem_im [MAX_PTS];

   logic                       accept;
   logic                       first;
   logic [PTS_W-1:0]           cur_pts;
   logic                       cur_inv;
   logic [LEN_W-1:0]           cur_len;
   logic [LEN_W-1:0]           cnt_next;
   logic                       frame_done;
   logic                       load;
   logic                       drain_last;
   logic signed [OUT_W-1:0]    ext_re;
   logic signed [OUT_W-1:0]    ext_im;

   // ------------------------------------------------------------------
   // input side
   // ------------------------------------------------------------------
   // transfer on valid and ready
   assign accept   = st.sink_valid & sink_ready_q;
   assign first    = ~in_frame_q;
   // count and direction taken at sop
   assign cur_pts  = first ? st.pts_in : pts_q;
   assign cur_inv  = first ? st.inverse : inv_q;
   assign cur_len  = frame_len(cur_pts);
   assign cnt_next = {1'b0, wr_idx_q} + LEN_W'(1);

   // frame checks on each accepted sample
   always_comb
   begin
      own_err_d  = own_err_q;
      frame_done = 1'b0;
      if (accept)
      begin
         if (first && !st.sink_sop)
         begin
            own_err_d = own_err_q | ERR_NO_SOP;
         end
         else if (st.sink_eop && cnt_next != cur_len)
         begin
            own_err_d = own_err_q | ERR_EARLY_EOP;
         end
         else if (cnt_next == cur_len && !st.sink_eop)
         begin
            own_err_d = own_err_q | ERR_NO_EOP;
         end
         else if (cnt_next == cur_len)
         begin
            frame_done = 1'b1;
         end
      end
   end

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_FILL:
         begin
            if (frame_done)
            begin
               state_d = ST_DRAIN;
            end
         end
         ST_DRAIN:
         begin
            if (load && drain_last)
            begin
               state_d = ST_FILL;
            end
         end
         default:
         begin
            state_d = ST_FILL;
         end
      endcase
   end

   // every register waits for clock enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q      <= ST_FILL;
         wr_idx_q     <= '0;
         in_frame_q   <= 1'b0;
         pts_q        <= '0;
         inv_q        <= 1'b0;
         out_pts_q    <= '0;
         out_inv_q    <= 1'b0;
         up_err_q     <= ERR_NONE;
         own_err_q    <= ERR_NONE;
         sink_ready_q <= 1'b0;
      end
      else if (st.clk_ena)
      begin
         state_q   <= state_d;
         own_err_q <= own_err_d;
         sink_ready_q <= (state_d == ST_FILL) && (own_err_d == ERR_NONE);
         if (accept)
         begin
            up_err_q   <= up_err_q | st.sink_error;
            pts_q      <= cur_pts;
            inv_q      <= cur_inv;
            in_frame_q <= ~frame_done;
            wr_idx_q   <= frame_done ? '0 : cnt_next[PTS_W-1:0];
         end
         if (frame_done)
         begin
            out_pts_q <= cur_pts;
            out_inv_q <= cur_inv;
         end
      end
   end

   // frame store; no reset, contents only read after being written
   always_ff @(posedge clk)
   begin
      if (st.clk_ena && accept)
      begin
         mem_re[wr_idx_q] <= st.sink_real;
         mem_im[wr_idx_q] <= st.sink_imag;
      end
   end

   // ------------------------------------------------------------------
   // output side
   // ------------------------------------------------------------------
   // a new sample loads only once the old one is taken
   assign load       = (state_q == ST_DRAIN) && (!src_valid_q || st.source_ready);
   assign drain_last = ({1'b0, rd_idx_q} + LEN_W'(1)) == frame_len(out_pts_q);
   // sign extension into the wider output parts
   assign ext_re = OUT_W'(mem_re[rd_idx_q]);
   assign ext_im = OUT_W'(mem_im[rd_idx_q]);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_idx_q    <= '0;
         src_valid_q <= 1'b0;
         src_sop_q   <= 1'b0;
         src_eop_q   <= 1'b0;
         src_err_q   <= ERR_NONE;
         src_exp_q   <= EXP_NONE;
         src_pts_q   <= '0;
         src_real_q  <= '0;
         src_imag_q  <= '0;
      end
      else if (st.clk_ena)
      begin
         src_err_q <= up_err_q | own_err_q;
         if (load)
         begin
            // valid raised with each stored sample
            src_valid_q <= 1'b1;
            src_sop_q   <= (rd_idx_q == '0);
            src_eop_q   <= drain_last;
            src_pts_q   <= out_pts_q;
            src_exp_q   <= EXP_NONE;
            src_real_q  <= ext_re;
            src_imag_q  <= out_inv_q ? -ext_im : ext_im;
            rd_idx_q    <= drain_last ? '0 : rd_idx_q + PTS_W'(1);
         end
         else if (st.source_ready)
         begin
            src_valid_q <= 1'b0;
         end
      end
   end

   assign st.sink_ready   = sink_ready_q;
   assign st.source_valid = src_valid_q;
   assign st.source_sop   = src_sop_q;
   assign st.source_eop   = src_eop_q;
   assign st.source_error = src_err_q;
   assign st.source_exp   = src_exp_q;
   assign st.pts_out      = src_pts_q;
   assign st.source_real  = src_real_q;
   assign st.source_imag  = src_imag_q;

endmodule : fsi_core
`default_nettype wire

// [src/fsi_ctrl.sv]
`default_nettype none
module fsi_ctrl
   import fsi_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   fsi_stream_if.user       st
);

   logic [31:0]             ctrl_q;
   logic                    tx_valid_q;
   logic [31:0]             tx_q;
   logic                    rx_full_q;
   logic                    rx_full_d;
   logic                    rx_sop_q;
   logic                    rx_eop_q;
   logic [ERR_W-1:0]        rx_err_q;
   logic [EXP_W-1:0]        rx_exp_q;
   logic [PTS_W-1:0]        rx_pts_q;
   logic [OUT_W-1:0]        rx_re_q;
   logic [OUT_W-1:0]        rx_im_q;
   logic                    src_ready_q;
   logic [31:0]             prdata_q;
   logic                    pready_q;
   logic                    pslverr_q;
   logic                    access;
   logic                    stall;
   logic                    take;
   logic                    pop;
   logic                    mapped;

   // ------------------------------------------------------------------
   // apb slave, answers one cycle into the access phase
   // ------------------------------------------------------------------
   assign access = psel && penable && !pready_q;
   // a second sample waits until the core took the first
   // held until valid and ready meet with clock enable high
   assign stall  = pwrite && paddr == OFS_TX && tx_valid_q;
   assign mapped = paddr == OFS_CTRL || paddr == OFS_TX || paddr == OFS_RX
                   || paddr == OFS_RXINFO;
   assign pop    = access && !pwrite && paddr == OFS_RX;
   // output counts as taken only on valid and ready
   // core holds its word while halted, so a halted cycle is no transfer
   assign take   = st.source_valid && src_ready_q && st.clk_ena;
   assign rx_full_d = (rx_full_q && !pop) || take;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
         ctrl_q    <= CTRL_RESET;
      end
      else
      begin
         pready_q  <= access && !stall;
         pslverr_q <= access && !stall && !mapped;
         prdata_q  <= '0;
         if (access && !stall && !pwrite)
         begin
            case (paddr)
               OFS_CTRL:   prdata_q <= ctrl_q;
               OFS_TX:     prdata_q <= tx_q;
               OFS_RX:     prdata_q <= {3'h0, rx_im_q, 3'h0, rx_re_q};
               OFS_RXINFO: prdata_q <= {12'h000, rx_pts_q, 2'h0, rx_exp_q,
                                        2'h0, rx_err_q, 1'b0, rx_eop_q,
                                        rx_sop_q, rx_full_q};
               default:    prdata_q <= '0;
            endcase
         end
         if (access && pwrite && paddr == OFS_CTRL)
         begin
            ctrl_q <= pwdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // sink side driver
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_valid_q <= 1'b0;
         tx_q       <= '0;
      end
      else
      begin
         if (access && pwrite && paddr == OFS_TX && !tx_valid_q)
         begin
            tx_valid_q <= 1'b1;
            tx_q       <= pwdata;
         end
         else if (tx_valid_q && st.sink_ready && st.clk_ena)
         begin
            tx_valid_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // source side receiver
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_full_q   <= 1'b0;
         src_ready_q <= 1'b0;
         rx_sop_q    <= 1'b0;
         rx_eop_q    <= 1'b0;
         rx_err_q    <= ERR_NONE;
         rx_exp_q    <= EXP_NONE;
         rx_pts_q    <= '0;
         rx_re_q     <= '0;
         rx_im_q     <= '0;
      end
      else
      begin
         rx_full_q   <= rx_full_d;
         // ready only while the holding word is free
         src_ready_q <= !rx_full_d;
         if (take)
         begin
            rx_sop_q <= st.source_sop;
            rx_eop_q <= st.source_eop;
            rx_err_q <= st.source_error;
            rx_exp_q <= st.source_exp;
            rx_pts_q <= st.pts_out;
            rx_re_q  <= st.source_real;
            rx_im_q  <= st.source_imag;
         end
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign st.clk_ena      = ctrl_q[CTRL_ENA_BIT];
   assign st.inverse      = ctrl_q[CTRL_INV_BIT];
   assign st.pts_in       = ctrl_q[CTRL_PTS_LSB +: PTS_W];
   // stays zero unless software injects a code
   assign st.sink_error   = ctrl_q[CTRL_ERR_LSB +: ERR_W];
   assign st.sink_valid   = tx_valid_q;
   // software sets sop and eop per sample
   assign st.sink_sop     = tx_q[TX_SOP_BIT];
   assign st.sink_eop     = tx_q[TX_EOP_BIT];
   assign st.sink_real    = tx_q[DATA_W-1:0];
   assign st.sink_imag    = tx_q[TX_IMAG_LSB +: DATA_W];
   assign st.source_ready = src_ready_q;

endmodule : fsi_ctrl
`default_nettype wire

// [src/fsi_pkg.sv]
`default_nettype none
package fsi_pkg;
   // ------------------------------------------------------------------
   // stream geometry
   // ------------------------------------------------------------------
   localparam int DATA_W   = 8;
   localparam int MAX_PTS  = 16;
   localparam int PTS_W    = $clog2(MAX_PTS);
   localparam int LEN_W    = PTS_W + 1;
   localparam int STAGES   = PTS_W / 2;
   // growth of 2.5 bits per radix-4 stage, taken whole
   localparam int GROWTH_W = (5 * STAGES) / 2;
   localparam int OUT_W    = DATA_W + GROWTH_W;
   localparam int EXP_W    = 6;
   localparam int ERR_W    = 2;

   // ------------------------------------------------------------------
   // error codes
   // ------------------------------------------------------------------
   localparam logic [ERR_W-1:0] ERR_NONE      = 2'h0;
   localparam logic [ERR_W-1:0] ERR_NO_SOP    = 2'h1;
   localparam logic [ERR_W-1:0] ERR_NO_EOP    = 2'h2;
   localparam logic [ERR_W-1:0] ERR_EARLY_EOP = 2'h3;

   localparam logic [EXP_W-1:0] EXP_NONE = 6'h00;

   // ------------------------------------------------------------------
   // controller registers (apb, byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_TX     = 8'h04;
   localparam logic [7:0] OFS_RX     = 8'h08;
   localparam logic [7:0] OFS_RXINFO = 8'h0c;

   localparam int CTRL_ENA_BIT = 0;
   localparam int CTRL_INV_BIT = 1;
   localparam int CTRL_PTS_LSB = 4;
   localparam int CTRL_ERR_LSB = 8;
   localparam int TX_IMAG_LSB  = 8;
   localparam int TX_SOP_BIT   = 16;
   localparam int TX_EOP_BIT   = 17;
   localparam int RX_IMAG_LSB  = 16;
   localparam int INFO_SOP_BIT = 1;
   localparam int INFO_EOP_BIT = 2;
   localparam int INFO_ERR_LSB = 4;
   localparam int INFO_EXP_LSB = 8;
   localparam int INFO_PTS_LSB = 16;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
endpackage : fsi_pkg
`default_nettype wire

// [src/fsi_stream_if.sv]
`default_nettype none
interface fsi_stream_if;
   import fsi_pkg::*;
   logic                    clk_ena;
   logic                    inverse;
   logic [PTS_W-1:0]        pts_in;
   logic                    sink_valid;
   logic                    sink_ready;
   logic                    sink_sop;
   logic                    sink_eop;
   logic [ERR_W-1:0]        sink_error;
   logic signed [DATA_W-1:0] sink_real;
   logic signed [DATA_W-1:0] sink_imag;
   logic                    source_valid;
   logic                    source_ready;
   logic                    source_sop;
   logic                    source_eop;
   logic [ERR_W-1:0]        source_error;
   logic signed [EXP_W-1:0] source_exp;
   logic [PTS_W-1:0]        pts_out;
   logic signed [OUT_W-1:0] source_real;
   logic signed [OUT_W-1:0] source_imag;

   modport core (
      input  clk_ena, inverse, pts_in, sink_valid, sink_sop, sink_eop, sink_error,
      input  sink_real, sink_imag, source_ready,
      output sink_ready, source_valid, source_sop, source_eop, source_error,
      output source_exp, pts_out, source_real, source_imag
   );
   modport user (
      output clk_ena, inverse, pts_in, sink_valid, sink_sop, sink_eop, sink_error,
      output sink_real, sink_imag, source_ready,
      input  sink_ready, source_valid, source_sop, source_eop, source_error,
      input  source_exp, pts_out, source_real, source_imag
   );
endinterface : fsi_stream_if
`default_nettype wire

// [test/fsi_props.sv]
`default_nettype none
module fsi_props
   import fsi_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    clk_ena,
   input wire logic                    sink_valid,
   input wire logic                    sink_ready,
   input wire logic                    sink_sop,
   input wire logic                    sink_eop,
   input wire logic [ERR_W-1:0]        sink_error,
   input wire logic                    source_valid,
   input wire logic                    source_ready,
   input wire logic                    source_sop,
   input wire logic                    source_eop,
   input wire logic [ERR_W-1:0]        source_error,
   input wire logic [PTS_W-1:0]        pts_out,
   input wire logic signed [OUT_W-1:0] source_real,
   input wire logic signed [OUT_W-1:0] source_imag
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------------
   // beat tracking
   // ------------------------------------------------------------------
   wire logic        sink_take = sink_valid && sink_ready && clk_ena;
   wire logic        out_take  = source_valid && source_ready && clk_ena;
   logic             in_open_q;
   logic             out_open_q;
   logic [4:0]       out_cnt_q;
   logic [ERR_W-1:0] seen_q;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         in_open_q <= 1'b0;
      else if (sink_take)
         in_open_q <= (in_open_q | sink_sop) & ~sink_eop;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         seen_q <= '0;
      else if (sink_take)
         seen_q <= seen_q | sink_error;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         out_open_q <= 1'b0;
         out_cnt_q  <= 5'h00;
      end
      else if (out_take)
      begin
         out_open_q <= ~source_eop;
         out_cnt_q  <= source_eop ? 5'h00 : out_cnt_q + 5'h01;
      end

   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   out_hold_a: assert property (
      source_valid && !(source_ready && clk_ena) |=> source_valid && $stable(source_real)
      && $stable(source_imag) && $stable(source_sop) && $stable(source_eop))
      else $error("output word changed before it was taken");
   ena_halt_a: assert property (
      !clk_ena |=> $stable(source_valid) && $stable(sink_ready) && $stable(pts_out))
      else $error("state moved while clock enable low");
   err_or_a: assert property (
      (source_error & $past(seen_q, 2)) == $past(seen_q, 2))
      else $error("upstream error code lost from output error");
   sop_first_a: assert property (
      out_take && !out_open_q |-> source_sop)
      else $error("first output beat without start marker");
   sop_mid_a: assert property (
      out_take && out_open_q |-> !source_sop)
      else $error("start marker inside a frame");
   eop_count_a: assert property (
      out_take && source_eop |-> out_cnt_q == {pts_out == 4'h0, pts_out} - 5'h01)
      else $error("end marker not on last beat of frame");
   pts_keep_a: assert property (
      source_valid && out_open_q |-> $stable(pts_out))
      else $error("point count changed inside a frame");
   ready_drop_a: assert property (
      sink_take && sink_eop |=> !sink_ready)
      else $error("ready stayed high after frame end");
   nosop_err_a: assert property (
      sink_take && !in_open_q && !sink_sop |-> ##[1:2] source_error[0])
      else $error("missing start marker not flagged");
endmodule : fsi_props
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
module testbench
   import fsi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk, rst_n;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          err_total, n_tests;

   fsi_stream_if st_if ();
   fsi_core fsi_core_i (.clk(clk), .rst_n(rst_n), .st(st_if));
   fsi_ctrl fsi_ctrl_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .st(st_if));
   fsi_props fsi_props_i (.clk(clk), .rst_n(rst_n), .clk_ena(st_if.clk_ena),
      .sink_valid(st_if.sink_valid), .sink_ready(st_if.sink_ready),
      .sink_sop(st_if.sink_sop), .sink_eop(st_if.sink_eop), .sink_error(st_if.sink_error),
      .source_valid(st_if.source_valid), .source_ready(st_if.source_ready),
      .source_sop(st_if.source_sop), .source_eop(st_if.source_eop),
      .source_error(st_if.source_error), .pts_out(st_if.pts_out),
      .source_real(st_if.source_real), .source_imag(st_if.source_imag));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   // one transfer; a stalled answer is waited for, never assumed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic se);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 100);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         $display("[ERR] bus answer expected 1 seen %b", pready);
         err_total++;
         summarize();
      end
   endtask : apb

   function automatic logic [15:0] smp(input int i);
      return {8'(128 - i * 7), 8'(128 + i * 29)};
   endfunction : smp

   // direction and length are rewritten mid-frame, clock held off for the first rewrite only
   task automatic run_frame(input logic inv, input logic [3:0] pts);
      int                 n, k;
      logic [31:0]        ctl, d, info;
      logic               se;
      logic [7:0]         re, im;
      logic signed [12:0] imx;
      n   = (pts == 4'h0) ? 16 : int'(pts);
      ctl = (32'(pts) << CTRL_PTS_LSB) | (32'(inv) << CTRL_INV_BIT) | 32'h1;
      apb(1'b1, OFS_CTRL, ctl, d, se);
      for (int i = 0; i < n; i++)
      begin
         if (i == 1)
         begin
            apb(1'b1, OFS_CTRL, ctl ^ 32'h53, d, se);
            apb(1'b1, OFS_CTRL, ctl ^ 32'h52, d, se);
         end
         apb(1'b1, OFS_TX, {14'h0, i == n - 1, i == 0, smp(i)}, d, se);
      end
      for (int i = 0; i < n; i++)
      begin
         k = 0;
         do
         begin
            apb(1'b0, OFS_RXINFO, 32'h0, d, se);
            k++;
         end
         while (d[0] !== 1'b1 && k < 20);
         if (d[0] !== 1'b1)
         begin
            $display("[ERR] output word expected 1 seen %b", d[0]);
            err_total++;
            summarize();
         end
         info = (32'(pts) << INFO_PTS_LSB) | (32'(i == n - 1) << INFO_EOP_BIT);
         info = info | (32'(i == 0) << INFO_SOP_BIT) | 32'h1;
         chk("frame info", info, d);
         apb(1'b0, OFS_RX, 32'h0, d, se);
         {im, re} = smp(i);
         imx = 13'(signed'(im));
         if (inv)
            imx = -imx;
         chk("frame data", {3'h0, imx, 3'h0, 13'(signed'(re))}, d);
      end
   endtask : run_frame

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic        se;
      err_total = 0;
      n_tests   = 0;
      rst_n     = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0, d, se);
      chk("ctrl reset", CTRL_RESET, d);
      apb(1'b0, 8'h10, 32'h0, d, se);
      chk("unmapped error", 32'h1, 32'(se));
      chk("unmapped data", 32'h0, d);
      run_frame(1'b1, 4'h4);
      run_frame(1'b0, 4'h0);
      run_frame(1'b1, 4'h1);
      // upstream code injected on a sample that lacks its start marker
      apb(1'b1, OFS_CTRL, 32'h1 | (32'(ERR_NO_EOP) << CTRL_ERR_LSB), d, se);
      apb(1'b1, OFS_TX, 32'h0000_0101, d, se);
      apb(1'b0, OFS_RXINFO, 32'h0, d, se);
      apb(1'b0, OFS_RXINFO, 32'h0, d, se);
      // no word follows an error, so the code is read off the source port itself
      d = 32'(st_if.source_error);
      chk("error code", 32'(ERR_NO_SOP | ERR_NO_EOP), d);
      chk("ready after error", 32'h0, 32'(st_if.sink_ready));
      // mid-run reset clears sticky codes, then a frame runs out without its end marker
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("error after reset", 32'(ERR_NONE), 32'(st_if.source_error));
      apb(1'b1, OFS_CTRL, 32'h0000_0021, d, se);
      apb(1'b1, OFS_TX, 32'h0001_0101, d, se);
      apb(1'b1, OFS_TX, 32'h0000_0202, d, se);
      apb(1'b0, OFS_RXINFO, 32'h0, d, se);
      d = 32'(st_if.source_error);
      chk("missing end code", 32'(ERR_NO_EOP), d);
      chk("ready after missing end", 32'h0, 32'(st_if.sink_ready));
      summarize();
   end
endmodule : testbench
`default_nettype wire
